// >>> rtl/mfx_exec.sv
// What this block does
// RL1 - integer products go to result pair, two cycles
// RL2 - fractional products shifted left one, two cycles
// RL3 - relative, pointer, absolute goto; 2/2/3 cycles
// RL4 - entries 4/4/5 cycles, exits from stack 5
// RL5 - equal compare skips next instruction, 1/2/3 cycles
// RL6 - compares set Z N V C H only
// RL7 - register bit skip, clear or set form
// RL8 - io bit skip, clear or set form
// RL9 - flag set branch to pc plus offset plus one
// RL10 - entries push return address in the same cycle as the redirect
// RL11 - skip costs one or two extra cycles
`timescale 1ns/10ps
`default_nettype none
module mfx_exec
  import mfx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic start,
  input wire mfx_op_type op,
  input wire logic [MFX_DW-1:0] opa,
  input wire logic [MFX_DW-1:0] opb,
  input wire logic [7:0] flags_in,
  input wire logic [2:0] bit_sel,
  input wire logic io_bit,
  input wire logic next_two_word,
  input wire logic [MFX_PCW-1:0] pc_in,
  input wire logic [MFX_OFFW-1:0] offset,
  input wire logic [MFX_PCW-1:0] target,
  input wire logic [MFX_PCW-1:0] pointer,
  input wire logic [MFX_PCW-1:0] stack_top,
  output logic busy_q,
  output logic done_q,
  output logic [MFX_PCW-1:0] pc_q,
  output logic pc_load_q,
  output logic [15:0] product_q,
  output logic product_we_q,
  output logic [7:0] flags_q,
  output logic flags_we_q,
  output logic [MFX_PCW-1:0] push_data_q,
  output logic push_q,
  output logic pop_q
);

  logic rst_s1_q;
  logic rst_n_q;
  logic take;
  logic [2:0] cnt_q;
  logic [2:0] cyc_d;
  logic [MFX_PCW-1:0] pc_d;
  logic [7:0] flags_d;
  logic wr_prod_d;
  logic wr_flags_d;
  logic push_d;
  logic pop_d;
  logic wr_prod_q;
  logic wr_flags_q;
  logic push_pend_q;
  logic pop_pend_q;
  logic fire;
  logic sign_a;
  logic sign_b;
  logic signed [17:0] mul_full;
  logic [15:0] prod_d;
  logic [8:0] diff;
  logic skip_cond;
  logic [MFX_PCW-1:0] rel_target;
  logic [MFX_PCW-1:0] skip_target;
  logic [2:0] skip_cyc;

  // release reset through two stages; assertion is asynchronous
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  assign take = ce & start & ~busy_q;
  assign fire = ce & busy_q & (cnt_q == 3'h0);

  // operand signs: signed forms extend opa, only full signed extends opb
  assign sign_a = opa[7] & (op inside {MFX_OP_SIGNED_PRODUCT, MFX_OP_FRACTIONAL_SIGNED_PRODUCT,
    MFX_OP_MIXED_SIGN_PRODUCT, MFX_OP_FRACTIONAL_MIXED_PRODUCT});
  assign sign_b = opb[7] &
    (op inside {MFX_OP_SIGNED_PRODUCT, MFX_OP_FRACTIONAL_SIGNED_PRODUCT});
  assign mul_full = $signed({{2{sign_a}}, opa}) * $signed({{2{sign_b}}, opb});

  // subtract with optional borrow; carry form uses the incoming carry flag
  assign diff = {1'b0, opa} - {1'b0, opb} -
    {8'h00, (op == MFX_OP_COMPARE_REGS_WITH_BORROW) & flags_in[MFX_FLAG_C]};

  assign rel_target = pc_in + {{(MFX_PCW-MFX_OFFW){offset[MFX_OFFW-1]}}, offset} + 16'h0001;
  // skipping a two-word instruction costs one more cycle
  assign skip_target = pc_in + (next_two_word ? 16'h0003 : 16'h0002); // [RL5] [RL7]
  assign skip_cyc = skip_cond ? (next_two_word ? MFX_CYC_SKIP_TWO : MFX_CYC_SKIP_ONE) :
    MFX_CYC_NO_SKIP; // [RL11]

  always_comb
  begin
    unique case (op)
      MFX_OP_COMPARE_SKIP_EQUAL: skip_cond = (opa == opb); // [RL5]
      MFX_OP_SKIP_REG_BIT_CLEAR: skip_cond = ~opb[bit_sel]; // [RL7]
      MFX_OP_SKIP_REG_BIT_SET: skip_cond = opb[bit_sel]; // [RL7]
      MFX_OP_SKIP_IO_BIT_CLEAR: skip_cond = ~io_bit; // [RL8]
      MFX_OP_SKIP_IO_BIT_SET: skip_cond = io_bit; // [RL8]
      default: skip_cond = 1'b0;
    endcase
  end

  always_comb
  begin
    cyc_d = MFX_CYC_CMP;
    pc_d = pc_in + 16'h0001;
    flags_d = flags_in;
    prod_d = mul_full[15:0];
    wr_prod_d = 1'b0;
    wr_flags_d = 1'b0;
    push_d = 1'b0;
    pop_d = 1'b0;
    unique case (op)
      MFX_OP_UNSIGNED_PRODUCT, MFX_OP_SIGNED_PRODUCT, MFX_OP_MIXED_SIGN_PRODUCT:
      begin
        cyc_d = MFX_CYC_MUL; // [RL1]
        wr_prod_d = 1'b1;
        wr_flags_d = 1'b1;
        flags_d[MFX_FLAG_C] = mul_full[15];
        flags_d[MFX_FLAG_Z] = (mul_full[15:0] == 16'h0000);
      end
      MFX_OP_FRACTIONAL_UNSIGNED_PRODUCT, MFX_OP_FRACTIONAL_SIGNED_PRODUCT,
      MFX_OP_FRACTIONAL_MIXED_PRODUCT:
      begin
        cyc_d = MFX_CYC_MUL; // [RL2]
        prod_d = {mul_full[14:0], 1'b0}; // [RL2]
        wr_prod_d = 1'b1;
        wr_flags_d = 1'b1;
        // carry is the bit shifted out
        flags_d[MFX_FLAG_C] = mul_full[15];
        flags_d[MFX_FLAG_Z] = ({mul_full[14:0], 1'b0} == 16'h0000);
      end
      MFX_OP_RELATIVE_GOTO: {cyc_d, pc_d} = {MFX_CYC_GOTO, rel_target}; // [RL3]
      MFX_OP_POINTER_GOTO: {cyc_d, pc_d} = {MFX_CYC_GOTO, pointer}; // [RL3]
      MFX_OP_ABSOLUTE_GOTO: {cyc_d, pc_d} = {MFX_CYC_ABS_GOTO, target}; // [RL3]
      MFX_OP_RELATIVE_SUBROUTINE_ENTRY:
        {cyc_d, pc_d, push_d} = {MFX_CYC_ENTRY, rel_target, 1'b1}; // [RL4] [RL10]
      MFX_OP_POINTER_SUBROUTINE_ENTRY:
        {cyc_d, pc_d, push_d} = {MFX_CYC_ENTRY, pointer, 1'b1}; // [RL4] [RL10]
      MFX_OP_ABSOLUTE_SUBROUTINE_ENTRY:
        {cyc_d, pc_d, push_d} = {MFX_CYC_ABS_ENTRY, target, 1'b1}; // [RL4] [RL10]
      MFX_OP_SUBROUTINE_EXIT, MFX_OP_INTERRUPT_EXIT:
        {cyc_d, pc_d, pop_d} = {MFX_CYC_EXIT, stack_top, 1'b1}; // [RL4]
      MFX_OP_COMPARE_REGS, MFX_OP_COMPARE_REGS_WITH_BORROW, MFX_OP_COMPARE_IMMEDIATE:
      begin
        wr_flags_d = 1'b1; // [RL6]
        flags_d[MFX_FLAG_C] = diff[8];
        flags_d[MFX_FLAG_N] = diff[7];
        flags_d[MFX_FLAG_V] = (opa[7] & ~opb[7] & ~diff[7]) | (~opa[7] & opb[7] & diff[7]);
        flags_d[MFX_FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & diff[3]) | (diff[3] & ~opa[3]);
        // carry form keeps zero only if it was already set
        flags_d[MFX_FLAG_Z] = (diff[7:0] == 8'h00) &
          ((op != MFX_OP_COMPARE_REGS_WITH_BORROW) | flags_in[MFX_FLAG_Z]);
      end
      MFX_OP_BRANCH_FLAG_SET:
      begin
        cyc_d = flags_in[bit_sel] ? MFX_CYC_BRANCH_TAKEN : MFX_CYC_NO_SKIP; // [RL9]
        pc_d = flags_in[bit_sel] ? rel_target : pc_in + 16'h0001; // [RL9]
      end
      MFX_OP_COMPARE_SKIP_EQUAL, MFX_OP_SKIP_REG_BIT_CLEAR, MFX_OP_SKIP_REG_BIT_SET,
      MFX_OP_SKIP_IO_BIT_CLEAR, MFX_OP_SKIP_IO_BIT_SET:
      begin
        cyc_d = skip_cyc; // [RL11]
        pc_d = skip_cond ? skip_target : pc_in + 16'h0001; // [RL5] [RL7] [RL8]
      end
    endcase
  end

  // sequencing: busy for exactly the instruction's cycle count
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      busy_q <= 1'b0;
      cnt_q <= 3'h0;
      done_q <= 1'b0;
    end
    else if (ce)
    begin
      done_q <= fire;
      if (take)
      begin
        busy_q <= 1'b1;
        cnt_q <= cyc_d - 3'h1;
      end
      else if (fire)
        busy_q <= 1'b0;
      else if (busy_q)
        cnt_q <= cnt_q - 3'h1;
    end
  end

  // results are captured at issue and stand until the next issue
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pc_q <= MFX_PC_RESET;
      product_q <= 16'h0000;
      flags_q <= 8'h00;
      push_data_q <= 16'h0000;
      wr_prod_q <= 1'b0;
      wr_flags_q <= 1'b0;
      push_pend_q <= 1'b0;
      pop_pend_q <= 1'b0;
    end
    else if (ce && take)
    begin
      pc_q <= pc_d;
      product_q <= prod_d;
      flags_q <= flags_d;
      // return point follows the entry: two words for the absolute form
      push_data_q <= pc_in + ((op == MFX_OP_ABSOLUTE_SUBROUTINE_ENTRY) ? 16'h0002 : 16'h0001);
      wr_prod_q <= wr_prod_d;
      wr_flags_q <= wr_flags_d;
      push_pend_q <= push_d;
      pop_pend_q <= pop_d;
    end
  end

  // one-cycle strobes; push lands in the same cycle as the redirect
  always_ff @(posedge ref_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pc_load_q <= 1'b0;
      product_we_q <= 1'b0;
      flags_we_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
    end
    else if (ce)
    begin
      pc_load_q <= fire;
      product_we_q <= fire & wr_prod_q; // [RL1] [RL2]
      flags_we_q <= fire & wr_flags_q; // [RL6]
      push_q <= fire & push_pend_q; // [RL10]
      pop_q <= fire & pop_pend_q; // [RL4]
    end
  end

  a_mul_two_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL1]
    take && op == MFX_OP_UNSIGNED_PRODUCT ##1 ce [*2] |=> product_we_q && !busy_q)
    else $error("integer product not written after two cycles");
  a_frac_shifted: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL2]
    take && op == MFX_OP_FRACTIONAL_UNSIGNED_PRODUCT |=> product_q[0] == 1'b0)
    else $error("fractional product not shifted");
  a_abs_goto_time: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL3]
    take && op == MFX_OP_ABSOLUTE_GOTO ##1 ce [*3] |=> pc_load_q && pc_q == $past(target, 4))
    else $error("absolute goto not taken in three cycles");
  a_entry_pushes: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL10]
    take && op == MFX_OP_RELATIVE_SUBROUTINE_ENTRY ##1 ce [*4]
      |=> push_q && push_data_q == $past(pc_in, 5) + 16'h0001)
    else $error("entry did not push return point");
  a_exit_time: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL4]
    take && op == MFX_OP_SUBROUTINE_EXIT ##1 ce [*5] |-> !pop_q ##1 pop_q)
    else $error("exit not five cycles");
  a_compare_no_product: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL6]
    take && op == MFX_OP_COMPARE_REGS ##1 ce |=> flags_we_q && !product_we_q && !push_q)
    else $error("compare wrote more than flags");
  a_skip_two_word: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL11]
    take && op == MFX_OP_COMPARE_SKIP_EQUAL && opa == opb && next_two_word ##1 ce [*3]
      |=> pc_load_q && pc_q == $past(pc_in, 4) + 16'h0003)
    else $error("two-word skip wrong");
  a_io_no_skip: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL8]
    take && op == MFX_OP_SKIP_IO_BIT_SET && !io_bit ##1 ce
      |=> pc_load_q && !flags_we_q && pc_q == $past(pc_in, 2) + 16'h0001)
    else $error("io skip without cause");
  a_branch_taken: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // [RL9]
    take && op == MFX_OP_BRANCH_FLAG_SET && flags_in[bit_sel] |=> pc_q == $past(rel_target))
    else $error("flag branch target wrong");

  c_product: cover property (@(posedge ref_clk) disable iff (!rst_n_q) product_we_q);
  c_push: cover property (@(posedge ref_clk) disable iff (!rst_n_q) push_q);
  c_pop: cover property (@(posedge ref_clk) disable iff (!rst_n_q) pop_q);
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (!rst_n_q) done_q && take);

endmodule : mfx_exec
`default_nettype wire

// >>> rtl/mfx_pkg.sv
package mfx_pkg;

  localparam int MFX_DW = 8;
  localparam int MFX_PCW = 16;
  localparam int MFX_OFFW = 12;

  // flag register bit positions
  localparam int MFX_FLAG_C = 0;
  localparam int MFX_FLAG_Z = 1;
  localparam int MFX_FLAG_N = 2;
  localparam int MFX_FLAG_V = 3;
  localparam int MFX_FLAG_H = 5;

  // cycles per instruction
  localparam logic [2:0] MFX_CYC_MUL = 3'h2;
  localparam logic [2:0] MFX_CYC_CMP = 3'h1;
  localparam logic [2:0] MFX_CYC_GOTO = 3'h2;
  localparam logic [2:0] MFX_CYC_ABS_GOTO = 3'h3;
  localparam logic [2:0] MFX_CYC_ENTRY = 3'h4;
  localparam logic [2:0] MFX_CYC_ABS_ENTRY = 3'h5;
  localparam logic [2:0] MFX_CYC_EXIT = 3'h5;
  localparam logic [2:0] MFX_CYC_NO_SKIP = 3'h1;
  localparam logic [2:0] MFX_CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] MFX_CYC_SKIP_TWO = 3'h3;
  localparam logic [2:0] MFX_CYC_BRANCH_TAKEN = 3'h2;

  localparam logic [15:0] MFX_PC_RESET = 16'h0000;

  typedef enum logic [4:0] {
    MFX_OP_UNSIGNED_PRODUCT,
    MFX_OP_SIGNED_PRODUCT,
    MFX_OP_MIXED_SIGN_PRODUCT,
    MFX_OP_FRACTIONAL_UNSIGNED_PRODUCT,
    MFX_OP_FRACTIONAL_SIGNED_PRODUCT,
    MFX_OP_FRACTIONAL_MIXED_PRODUCT,
    MFX_OP_RELATIVE_GOTO,
    MFX_OP_POINTER_GOTO,
    MFX_OP_ABSOLUTE_GOTO,
    MFX_OP_RELATIVE_SUBROUTINE_ENTRY,
    MFX_OP_POINTER_SUBROUTINE_ENTRY,
    MFX_OP_ABSOLUTE_SUBROUTINE_ENTRY,
    MFX_OP_SUBROUTINE_EXIT,
    MFX_OP_INTERRUPT_EXIT,
    MFX_OP_COMPARE_SKIP_EQUAL,
    MFX_OP_COMPARE_REGS,
    MFX_OP_COMPARE_REGS_WITH_BORROW,
    MFX_OP_COMPARE_IMMEDIATE,
    MFX_OP_SKIP_REG_BIT_CLEAR,
    MFX_OP_SKIP_REG_BIT_SET,
    MFX_OP_SKIP_IO_BIT_CLEAR,
    MFX_OP_SKIP_IO_BIT_SET,
    MFX_OP_BRANCH_FLAG_SET
  } mfx_op_type;

endpackage : mfx_pkg

// >>> testbench/mfx_exec_bench.sv
`timescale 1ns/10ps
`default_nettype none
module mfx_exec_bench
  import mfx_pkg::*;
;
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] prod;
    logic [7:0] flags;
    logic [15:0] push;
    logic [2:0] cyc;
    logic [4:0] stb;
  } mfx_expect_type;

  logic ref_clk, nrst, ce, start, io_bit, next_two_word;
  mfx_op_type op;
  logic [7:0] opa, opb, flags_in;
  logic [2:0] bit_sel;
  logic [15:0] pc_in, target, pointer, stack_top;
  logic [11:0] offset;
  logic busy_q, done_q, pc_load_q, product_we_q, flags_we_q, push_q, pop_q;
  logic [15:0] pc_q, product_q, push_data_q;
  logic [7:0] flags_q;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 34122;
  int cycles = 0;

  mfx_exec mfx_exec_inst (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .start(start), .op(op),
    .opa(opa), .opb(opb), .flags_in(flags_in), .bit_sel(bit_sel), .io_bit(io_bit),
    .next_two_word(next_two_word), .pc_in(pc_in), .offset(offset), .target(target),
    .pointer(pointer), .stack_top(stack_top), .busy_q(busy_q), .done_q(done_q),
    .pc_q(pc_q), .pc_load_q(pc_load_q), .product_q(product_q), .product_we_q(product_we_q),
    .flags_q(flags_q), .flags_we_q(flags_we_q), .push_data_q(push_data_q),
    .push_q(push_q), .pop_q(pop_q));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  // reads the inputs once they have settled, before the take edge
  function automatic mfx_expect_type predict();
    mfx_expect_type e;
    logic signed [17:0] sa, sb, p;
    logic [15:0] rel;
    logic [7:0] r;
    logic c, sk, bw;
    e = '0;
    e.pc = pc_in + 16'h0001;
    e.flags = flags_in;
    e.cyc = 3'h1;
    e.stb = 5'b10000;
    rel = pc_in + {{4{offset[11]}}, offset} + 16'h0001;
    sk = 1'b0;
    bw = (op == MFX_OP_COMPARE_REGS_WITH_BORROW);
    case (op)
      MFX_OP_COMPARE_REGS, MFX_OP_COMPARE_REGS_WITH_BORROW, MFX_OP_COMPARE_IMMEDIATE:
      begin
        c = bw & flags_in[MFX_FLAG_C];
        r = opa - opb - {7'h00, c};
        e.flags[MFX_FLAG_Z] = (r == 8'h00) & (~bw | flags_in[MFX_FLAG_Z]);
        e.flags[MFX_FLAG_N] = r[7];
        e.flags[MFX_FLAG_V] = (opa[7] & ~opb[7] & ~r[7]) | (~opa[7] & opb[7] & r[7]);
        e.flags[MFX_FLAG_C] = (~opa[7] & opb[7]) | (opb[7] & r[7]) | (r[7] & ~opa[7]);
        e.flags[MFX_FLAG_H] = (~opa[3] & opb[3]) | (opb[3] & r[3]) | (r[3] & ~opa[3]);
        e.stb = 5'b10100;
      end
      MFX_OP_RELATIVE_GOTO: {e.pc, e.cyc} = {rel, 3'h2};
      MFX_OP_POINTER_GOTO: {e.pc, e.cyc} = {pointer, 3'h2};
      MFX_OP_ABSOLUTE_GOTO: {e.pc, e.cyc} = {target, 3'h3};
      MFX_OP_RELATIVE_SUBROUTINE_ENTRY: {e.pc, e.cyc, e.stb} = {rel, 3'h4, 5'b10010};
      MFX_OP_POINTER_SUBROUTINE_ENTRY: {e.pc, e.cyc, e.stb} = {pointer, 3'h4, 5'b10010};
      MFX_OP_ABSOLUTE_SUBROUTINE_ENTRY:
      begin
        {e.pc, e.cyc, e.stb} = {target, 3'h5, 5'b10010};
        e.push = pc_in + 16'h0002;
      end
      MFX_OP_SUBROUTINE_EXIT, MFX_OP_INTERRUPT_EXIT:
        {e.pc, e.cyc, e.stb} = {stack_top, 3'h5, 5'b10001};
      MFX_OP_COMPARE_SKIP_EQUAL: sk = (opa == opb);
      MFX_OP_SKIP_REG_BIT_CLEAR: sk = ~opb[bit_sel];
      MFX_OP_SKIP_REG_BIT_SET: sk = opb[bit_sel];
      MFX_OP_SKIP_IO_BIT_CLEAR: sk = ~io_bit;
      MFX_OP_SKIP_IO_BIT_SET: sk = io_bit;
      MFX_OP_BRANCH_FLAG_SET:
        if (flags_in[bit_sel])
          {e.pc, e.cyc} = {rel, 3'h2};
      default:
      begin
        sa = {{10{opa[7] & (op != MFX_OP_UNSIGNED_PRODUCT)
          & (op != MFX_OP_FRACTIONAL_UNSIGNED_PRODUCT)}}, opa};
        sb = {{10{opb[7] & ((op == MFX_OP_SIGNED_PRODUCT)
          | (op == MFX_OP_FRACTIONAL_SIGNED_PRODUCT))}}, opb};
        p = sa * sb;
        e.prod = (op >= MFX_OP_FRACTIONAL_UNSIGNED_PRODUCT) ? {p[14:0], 1'b0} : p[15:0];
        e.flags[MFX_FLAG_C] = p[15];
        e.flags[MFX_FLAG_Z] = (e.prod == 16'h0000);
        e.cyc = 3'h2;
        e.stb = 5'b11100;
      end
    endcase
    if (sk)
      {e.pc, e.cyc} = next_two_word ? {pc_in + 16'h0003, 3'h3} : {pc_in + 16'h0002, 3'h2};
    if (op != MFX_OP_ABSOLUTE_SUBROUTINE_ENTRY)
      e.push = pc_in + 16'h0001;
    return e;
  endfunction : predict

  task automatic do_op(input mfx_op_type o, input int i);
    logic [7:0] cv [4];
    logic [7:0] a, b;
    mfx_expect_type e;
    int cnt;
    cv = '{8'h00, 8'h80, 8'hff, 8'h01};
    a = (i < 4) ? cv[i] : 8'($random(seed));
    b = (i < 4) ? cv[3 - i] : (i == 4) ? a : 8'($random(seed));
    @(posedge ref_clk);
    start <= 1'b1;
    op <= o;
    opa <= a;
    opb <= b;
    {flags_in, bit_sel, io_bit, next_two_word} <= 13'($random(seed));
    {pc_in, offset} <= 28'($random(seed));
    {target, pointer} <= 32'($random(seed));
    stack_top <= 16'($random(seed));
    #1 e = predict();
    @(posedge ref_clk);
    // held start with new inputs must be ignored while busy
    op <= MFX_OP_SUBROUTINE_EXIT;
    stack_top <= ~stack_top;
    opa <= ~opa;
    // one frozen cycle inside the sixth pass (i == 5) stretches the instruction by one
    ce <= (i != 5);
    #1 check(busy_q, 1'b1);
    cnt = 0;
    while (cnt < 8 && done_q !== 1'b1)
    begin
      @(posedge ref_clk);
      start <= 1'b0;
      ce <= 1'b1;
      cnt++;
      #1;
    end
    check(cnt, e.cyc + ((i == 5) ? 3'h1 : 3'h0));
    check(pc_q, e.pc);
    check({busy_q, pc_load_q, product_we_q, flags_we_q, push_q, pop_q}, {1'b0, e.stb});
    if (e.stb[3])
      check(product_q, e.prod);
    if (e.stb[2])
      check(flags_q, e.flags);
    if (e.stb[1])
      check(push_data_q, e.push);
    // strobes stand for one cycle only
    @(posedge ref_clk);
    #1 check({done_q, pc_load_q, product_we_q, flags_we_q, push_q, pop_q}, 6'h00);
  endtask : do_op

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial
  begin
    {nrst, ce, start, io_bit, next_two_word, opa, opb, flags_in, bit_sel} = '0;
    {pc_in, target, pointer, stack_top, offset} = '0;
    op = MFX_OP_UNSIGNED_PRODUCT;
    repeat (2) @(posedge ref_clk);
    #1 check({pc_q, busy_q, done_q}, 18'h0_0000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // clock enable low must keep a request from being taken
    start <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 check(busy_q, 1'b0);
    @(posedge ref_clk);
    start <= 1'b0;
    ce <= 1'b1;
    for (int i = 0; i < 10; i++)
      for (int k = 0; k <= int'(MFX_OP_BRANCH_FLAG_SET); k++)
        do_op(mfx_op_type'(k), i);
    print_verdict();
  end
endmodule : mfx_exec_bench
`default_nettype wire
